// *** verilog/rvm_pkg.sv ***
// Package: vector map constants for the reset and interrupt vector block
package rvm_pkg;
   localparam int ADDR_W      = 13;           // Program word address width
   localparam int SRC_N       = 26;           // Interrupt sources (vectors 2..27)
   localparam int SRC_W       = 5;            // Source index width
   localparam logic [12:0] RESET_VEC      = 13'h0000; // Application reset address
   localparam logic [12:0] APP_IVT_BASE   = 13'h0002; // Application vector base
   localparam logic [12:0] BOOT_IVT_OFS   = 13'h0002; // Boot base offset of table
   localparam logic [12:0] VEC_STRIDE     = 13'h0002; // Words between vectors
   localparam logic [12:0] BOOT_RESET_DEF = 13'h1c00; // Default boot section start
   localparam logic FUSE_PROGRAMMED = 1'b0;   // Fuse value 0 means programmed
   // Source indices, vector number minus two
   localparam logic [4:0] SRC_EXT0    = 5'h00;
   localparam logic [4:0] SRC_EXT1    = 5'h01;
   localparam logic [4:0] SRC_PCG0    = 5'h02;
   localparam logic [4:0] SRC_PCG1    = 5'h03;
   localparam logic [4:0] SRC_PCG2    = 5'h04;
   localparam logic [4:0] SRC_WDOG    = 5'h05;
   localparam logic [4:0] SRC_T2CA    = 5'h06;
   localparam logic [4:0] SRC_T2CB    = 5'h07;
   localparam logic [4:0] SRC_T2OV    = 5'h08;
   localparam logic [4:0] SRC_T1CP    = 5'h09;
   localparam logic [4:0] SRC_T1CA    = 5'h0a;
   localparam logic [4:0] SRC_T1CB    = 5'h0b;
   localparam logic [4:0] SRC_T1OV    = 5'h0c;
   localparam logic [4:0] SRC_T0CA    = 5'h0d;
   localparam logic [4:0] SRC_T0CB    = 5'h0e;
   localparam logic [4:0] SRC_T0OV    = 5'h0f;
   localparam logic [4:0] SRC_SERXFER = 5'h10;
   localparam logic [4:0] SRC_RXDONE  = 5'h11;
   localparam logic [4:0] SRC_TXEMPTY = 5'h12;
   localparam logic [4:0] SRC_TXDONE  = 5'h13;
   localparam logic [4:0] SRC_CONV    = 5'h14;
   localparam logic [4:0] SRC_NVRDY   = 5'h15;
   localparam logic [4:0] SRC_ACMP    = 5'h16;
   localparam logic [4:0] SRC_TWOW    = 5'h17;
   localparam logic [4:0] SRC_SPRDY   = 5'h18;
   localparam logic [4:0] SRC_RXSTART = 5'h19;
   // Fetch request kinds
   typedef enum logic [1:0] {
      RVM_IDLE  = 2'b00,
      RVM_RESET = 2'b01,
      RVM_IRQ   = 2'b10
   } rvm_req_e;
endpackage

// *** verilog/rvm_vec_offset.sv ***
// Vector table offset for one source index
module rvm_vec_offset
   import rvm_pkg::*;
(
   input  wire logic [rvm_pkg::SRC_W-1:0]  srcIdx,
   output logic      [rvm_pkg::ADDR_W-1:0] tableOfs,
   output logic                            srcValid
);
   import rvm_pkg::*;

   // Offset is stride times index, spaced two words apart
   always_comb
   begin
      tableOfs = 13'(VEC_STRIDE * 13'(srcIdx));
      srcValid = (srcIdx <= SRC_RXSTART);
   end
endmodule

// *** verilog/rvm_vector_map.sv ***
// Reset and interrupt vector address generator for the core fetch logic

// Summary of operation
// - After any system reset, fetch starts at 0x0000 unless the boot fuse relocates it.
// - External request zero uses 0x0002 and request one 0x0004 from the active base.
// - Pin change groups use 0x0006, 0x0008, 0x000A and the watchdog uses 0x000C.
// - Second 8-bit timer compare A, compare B and overflow use 0x000E, 0x0010, 0x0012.
// - 16-bit timer capture, compare A, compare B, overflow use 0x0014 to 0x001A.
// - First 8-bit timer compare A, compare B and overflow use 0x001C, 0x001E, 0x0020.
// - Serial transfer 0x0022, receive 0x0024, tx empty 0x0026, tx done 0x0028, start 0x0034.
// - Conversion 0x002A, nv data 0x002C, comparator 0x002E, two-wire 0x0030, program 0x0032.
// - With vector select set, each vector is the table offset added to the boot start plus 0x0002.
// - Fuse 1 resets to 0x000, fuse 0 to the boot address; select picks the vector base.
// - An interrupt vector is only fetched for an enabled interrupt that the core has taken.
module rvm_vector_map
   import rvm_pkg::*;
#(
   parameter logic [12:0] BOOT_RESET_ADDR = rvm_pkg::BOOT_RESET_DEF
)
(
   input  wire logic                        clk_sys,
   input  wire logic                        sys_rst,
   input  wire logic                        boot_reset_fuse,
   input  wire logic                        vector_select_boot,
   input  wire logic                        irqAccept,
   input  wire logic                        irqEnabled,
   input  wire logic [rvm_pkg::SRC_W-1:0]   irqSource,
   output logic                             vecLoad,
   output logic      [rvm_pkg::ADDR_W-1:0]  vecAddr,
   output rvm_pkg::rvm_req_e                vecKind
);
   import rvm_pkg::*;

   // Start-up phases around reset release
   typedef enum logic [1:0] {
      RVM_PH_HOLD   = 2'b00,  // Reset held
      RVM_PH_VECTOR = 2'b01,  // Reset vector presented
      RVM_PH_RUN    = 2'b10   // Interrupt vectors served
   } rvm_phase_e;

   logic [ADDR_W-1:0] tableOfs;
   logic              srcValid;
   logic              srcListed;
   logic              acceptOk;
   logic [ADDR_W-1:0] bootBase;
   logic [ADDR_W-1:0] ivtBase;
   logic [ADDR_W-1:0] irqAddr;
   logic [ADDR_W-1:0] resetAddr;
   logic              resetPend;
   logic              fuseLatched;
   rvm_phase_e        phase;
   rvm_phase_e        next_phase;
   logic              next_load;
   logic [ADDR_W-1:0] next_addr;
   rvm_req_e          next_kind;

   // Fixed table offset of the requested source
   rvm_vec_offset uOfs
   (
      .srcIdx   (irqSource),
      .tableOfs (tableOfs),
      .srcValid (srcValid)
   );

   // Only sources that stand in the vector table may be served
   always_comb
   begin
      srcListed = 1'b0;
      case (irqSource)
         SRC_EXT0,
         SRC_EXT1:    srcListed = 1'b1;
         SRC_PCG0,
         SRC_PCG1,
         SRC_PCG2,
         SRC_WDOG:    srcListed = 1'b1;
         SRC_T2CA,
         SRC_T2CB,
         SRC_T2OV:    srcListed = 1'b1;
         SRC_T1CP,
         SRC_T1CA,
         SRC_T1CB,
         SRC_T1OV:    srcListed = 1'b1;
         SRC_T0CA,
         SRC_T0CB,
         SRC_T0OV:    srcListed = 1'b1;
         SRC_SERXFER,
         SRC_RXDONE,
         SRC_TXEMPTY,
         SRC_TXDONE,
         SRC_RXSTART: srcListed = 1'b1;
         SRC_CONV,
         SRC_NVRDY,
         SRC_ACMP,
         SRC_TWOW,
         SRC_SPRDY:   srcListed = 1'b1;
         default:     srcListed = 1'b0;  // Beyond the table
      endcase
   end

   // Accept counts only for an enabled, listed source
   always_comb
   begin
      acceptOk = irqAccept && irqEnabled && srcValid && srcListed;
   end

   // Fuse captured while reset is held, a strap sampled by the clock
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         fuseLatched <= boot_reset_fuse;
   end

   // Reset vector follows the fuse
   always_comb
   begin
      if (fuseLatched == FUSE_PROGRAMMED)
         resetAddr = BOOT_RESET_ADDR;
      else
         resetAddr = RESET_VEC;
   end

   // Boot-section table base, boot start plus the fixed table offset
   always_comb
   begin
      bootBase = ADDR_W'(BOOT_RESET_ADDR + BOOT_IVT_OFS);
   end

   // Active vector base from the select bit
   always_comb
   begin
      if (vector_select_boot)
         ivtBase = bootBase;
      else
         ivtBase = APP_IVT_BASE;
   end

   // Interrupt vector, table offset added to the active base
   always_comb
   begin
      irqAddr = ADDR_W'(ivtBase + tableOfs);
   end

   // Start-up phase, forced to hold while reset is high
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         phase <= RVM_PH_HOLD;
      else
         phase <= next_phase;
   end

   // Leave hold for one reset vector cycle, then serve interrupts
   always_comb
   begin
      next_phase = phase;
      case (phase)
         RVM_PH_HOLD:
            next_phase = RVM_PH_VECTOR;
         RVM_PH_VECTOR:
            next_phase = RVM_PH_RUN;
         RVM_PH_RUN:
            next_phase = RVM_PH_RUN;
         default:
            next_phase = RVM_PH_RUN;  // Stray code gives no spurious reset load
      endcase
   end

   // One reset vector load right after release
   always_comb
   begin
      resetPend = (phase == RVM_PH_HOLD);
   end

   // Choose what to present next; reset has precedence
   always_comb
   begin
      next_load = 1'b0;
      next_addr = vecAddr;
      next_kind = RVM_IDLE;
      if (resetPend)
      begin
         next_load = 1'b1;
         next_addr = resetAddr;
         next_kind = RVM_RESET;
      end
      else if (acceptOk)
      begin
         next_load = 1'b1;
         next_addr = irqAddr;
         next_kind = RVM_IRQ;
      end
   end

   // Load strobe toward the program counter, one cycle per vector
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         vecLoad <= 1'b0;
      else
         vecLoad <= next_load;
   end

   // Vector address, held between loads
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         vecAddr <= RESET_VEC;
      else
         vecAddr <= next_addr;
   end

   // Kind of the vector now presented
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         vecKind <= RVM_IDLE;
      else
         vecKind <= next_kind;
   end
endmodule

// *** tb/rvm_vector_map_checker.sv ***
// Checker for the reset and interrupt vector map outputs
module rvm_vector_map_checker
   import rvm_pkg::*;
#(parameter logic [12:0] BOOT_RESET_ADDR = 13'h1c00)
(
   input wire logic              clk_sys,
   input wire logic              sys_rst,
   input wire logic              boot_reset_fuse,
   input wire logic              vector_select_boot,
   input wire logic              irqAccept,
   input wire logic              irqEnabled,
   input wire logic [4:0]        irqSource,
   input wire logic              vecLoad,
   input wire logic [12:0]       vecAddr,
   input wire rvm_pkg::rvm_req_e vecKind
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        take;
   logic [12:0] expAddr;
   // Accepted request and its expected vector
   assign take = irqAccept && irqEnabled && irqSource <= 5'h19;
   assign expAddr = (vector_select_boot ? BOOT_RESET_ADDR : 13'h0000) + 13'h0002
      + {7'h00, irqSource, 1'b0};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   rst_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !vecLoad)
      else $error("load during reset");
   reset_vec_a: assert property ($fell(sys_rst) |=> vecLoad && vecKind == RVM_RESET &&
      vecAddr == ($past(boot_reset_fuse, 2) ? 13'h0000 : BOOT_RESET_ADDR))
      else $error("reset addr");
   irq_load_a: assert property (take && !$fell(sys_rst) |=> vecLoad &&
      vecKind == RVM_IRQ && vecAddr == $past(expAddr)) else $error("irq vector");
   refuse_a: assert property (!take && !$fell(sys_rst) |=> !vecLoad)
      else $error("load without accept");
   idle_kind_a: assert property (!vecLoad |-> vecKind == RVM_IDLE) else $error("kind");
   addr_hold_a: assert property (!vecLoad && !$fell(sys_rst) |-> $stable(vecAddr))
      else $error("addr moved");
   rst_only_a: assert property (vecKind == RVM_RESET |-> $past(sys_rst, 2))
      else $error("late reset load");
   irq_kind_a: assert property (vecKind == RVM_IRQ |-> $past(irqAccept && irqEnabled))
      else $error("irq kind");
   cover property (vecKind == RVM_RESET && vecAddr != 13'h0000);
   cover property (vecKind == RVM_IRQ && vector_select_boot);
   cover property (irqAccept && !irqEnabled);
endmodule
bind rvm_vector_map rvm_vector_map_checker #(.BOOT_RESET_ADDR(BOOT_RESET_ADDR)) rvm_chk_inst (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .boot_reset_fuse(boot_reset_fuse),
   .vector_select_boot(vector_select_boot), .irqAccept(irqAccept), .irqEnabled(irqEnabled),
   .irqSource(irqSource), .vecLoad(vecLoad), .vecAddr(vecAddr), .vecKind(vecKind));

// *** tb/rvm_core_fetch.sv ***
// Core fetch model: program counter fed by the vector map
module rvm_core_fetch
(
   input wire logic        clk_sys,
   input wire logic        vecLoad,
   input wire logic [12:0] vecAddr,
   output logic     [12:0] pc
);
   timeunit 1ns;
   timeprecision 1ps;
   // Jump on a load, else step one word
   always_ff @(posedge clk_sys)
      pc <= vecLoad ? vecAddr : pc + 13'h0001;
endmodule

// *** tb/tb.sv ***
// Bench for the vector map with a core fetch model
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rvm_pkg::*;
   localparam logic [12:0] BRA = 13'h0800;
   logic        clk_sys = 1'b0, sys_rst = 1'b1, bootFuse = 1'b1, vecSel = 1'b0;
   logic        irqAccept = 1'b0, irqEnabled = 1'b1, vecLoad;
   logic [4:0]  irqSource = 5'h00;
   logic [12:0] vecAddr, pc;
   rvm_req_e    vecKind;
   int          n_fail = 0, checked = 0, cyc = 0;
   rvm_vector_map #(.BOOT_RESET_ADDR(BRA)) rvm_vector_map_inst (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .boot_reset_fuse(bootFuse), .vector_select_boot(vecSel),
      .irqAccept(irqAccept), .irqEnabled(irqEnabled), .irqSource(irqSource),
      .vecLoad(vecLoad), .vecAddr(vecAddr), .vecKind(vecKind));
   rvm_core_fetch rvm_core_fetch_inst (.clk_sys(clk_sys), .vecLoad(vecLoad),
      .vecAddr(vecAddr), .pc(pc));
   // Clock and hang limit
   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 600)
      begin
         n_fail++;
         test_done();
      end
   end
   task automatic chk(input logic [12:0] got, input logic [12:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("checks=%0d fails=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Reset, with a request in the first cycle after release, while still in hold, that must drop
   task automatic reset_run(input logic f, input int n);
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      bootFuse <= f;
      repeat (n) @(posedge clk_sys);
      sys_rst <= 1'b0;
      irqAccept <= 1'b1;
      @(posedge clk_sys);
      irqAccept <= 1'b0;
      #1;
      chk(vecAddr, f ? 13'h0000 : BRA);
      chk({10'h0, vecLoad, vecKind}, {10'h0, 1'b1, RVM_RESET});
      @(posedge clk_sys);
      #1;
      chk({12'h0, vecLoad}, 13'h0000);
   endtask
   // Every source back to back on one vector base
   task automatic sweep(input logic sel);
      logic [12:0] base;
      logic [12:0] want;
      base = sel ? BRA + 13'h0002 : 13'h0002;
      for (int i = 0; i <= 26; i++)
      begin
         @(posedge clk_sys);
         vecSel <= sel;
         irqSource <= 5'(i);
         irqAccept <= (i < 26);
         #1;
         want = base + 13'(2 * (i - 1));
         if (i > 0)
            chk(vecAddr, want);
      end
      chk({10'h0, vecLoad, vecKind}, {10'h0, 1'b1, RVM_IRQ});
      @(posedge clk_sys);
      #1;
      chk(pc, base + 13'h0032);
   endtask
   // Disabled source and indices past the table give no load
   task automatic refuse();
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk_sys);
         irqEnabled <= (i != 0);
         irqSource <= (i == 0) ? SRC_T1CA : ((i == 1) ? 5'h1a : 5'h1f);
         irqAccept <= 1'b1;
         @(posedge clk_sys);
         irqAccept <= 1'b0;
         irqEnabled <= 1'b1;
         #1;
         chk({12'h0, vecLoad}, 13'h0000);
      end
   endtask
   initial
   begin
      reset_run(1'b1, 19);
      sweep(1'b0);
      refuse();
      sweep(1'b1);
      reset_run(1'b0, 2);
      sweep(1'b1);
      test_done();
   end
endmodule
